// [fcl_pkg.sv]
// Functional notes
// - CPU and debug port both read fuses; only the debug port programs or clears.
// - Fuse contents hold through every system reset and read valid from power-up.
// - Loader copies watchdog, oscillator, system A, lock and (after power-on) brown-out fuses to targets at the end of start-up.
// - Newly programmed fuse values reach targets only after the next reset.
// - Watchdog fuse bits 7:4 load the watchdog window field.
// - Watchdog fuse bits 3:0 load the watchdog timeout field.
// - Brown-out settings reload only after power-on reset; other resets keep them.
// - Brown-out fuse bits 7:5 load the brown-out level; codes 0, 2, 7 valid.
// - Brown-out fuse bit 4 loads sample rate: 0 is 1 kHz, 1 is 125 Hz.
// - Brown-out fuse bits 3:2 load active mode: off, on, sampled, on with wait.
// - Brown-out fuse bits 1:0 load sleep mode: off, on, sampled, reserved.
// - Oscillator fuse bit 7 loads calibration lock; set blocks run-time calibration writes.
// - Oscillator fuse bits 1:0 pick 16 or 20 MHz and its factory calibration.
// - System fuse A bits 7:6 select boot CRC source: flash, boot, both, none.
// - System fuse A bit 3 makes the reset pin GPIO or reset input.
// - System fuse A bit 0 keeps EEPROM on chip erase unless device is locked.
// - Factory defaults: oscillator 0x02, system A 0xc0, watchdog and brown-out zero.
// - Without the valid lock key the debug port gets no system bus access.
package fcl_pkg;

    localparam int unsigned FCL_NUM_BYTES = 11;

    localparam logic [3:0] FCL_OFS_WDT  = 4'h0;
    localparam logic [3:0] FCL_OFS_BOD  = 4'h1;
    localparam logic [3:0] FCL_OFS_OSC  = 4'h2;
    localparam logic [3:0] FCL_OFS_SYSA = 4'h5;
    localparam logic [3:0] FCL_OFS_SYSB = 4'h6;
    localparam logic [3:0] FCL_OFS_APP  = 4'h7;
    localparam logic [3:0] FCL_OFS_BOOT = 4'h8;
    localparam logic [3:0] FCL_OFS_LOCK = 4'ha;

    localparam logic [7:0] FCL_ZERO      = 8'h00;
    localparam logic [7:0] FCL_LOCK_OPEN = 8'hc5;

    // Factory image, indexed by offset; reserved slots stay zero
    localparam logic [7:0] FCL_FACTORY [FCL_NUM_BYTES] = '{
        8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'hc0,
        8'h07, 8'h00, 8'h00, 8'h00, 8'hc5
    };

    localparam logic [1:0] FCL_FREQ_16M = 2'h1;
    localparam logic [1:0] FCL_FREQ_20M = 2'h2;

    typedef enum logic [1:0] {
        FCL_CRC_FLASH        = 2'b00,
        FCL_CRC_BOOT         = 2'b01,
        FCL_CRC_BOOT_AND_APP = 2'b10,
        FCL_CRC_DISABLED     = 2'b11
    } fcl_crc_t;

    typedef enum logic [1:0] {
        FCL_BOD_OFF     = 2'b00,
        FCL_BOD_ON      = 2'b01,
        FCL_BOD_SAMPLED = 2'b10,
        FCL_BOD_ON_WAIT = 2'b11
    } fcl_bod_mode_t;

    typedef enum logic {
        FCL_ST_LOAD = 1'b0,
        FCL_ST_RUN  = 1'b1
    } fcl_state_t;

    typedef struct packed {
        logic [3:0] window;
        logic [3:0] timeout;
    } fcl_wdt_t;

    typedef struct packed {
        logic [2:0]    brownout_level;
        logic          brownout_sample_rate;
        fcl_bod_mode_t active_mode;
        fcl_bod_mode_t sleep_mode;
    } fcl_bod_t;

    typedef struct packed {
        logic       calibration_lock;
        logic [4:0] unused;
        logic [1:0] osc_frequency_select;
    } fcl_osc_t;

    typedef struct packed {
        fcl_crc_t   boot_crc_source;
        logic [1:0] unused_hi;
        logic       reset_pin_function;
        logic [1:0] unused_lo;
        logic       eeprom_keep_on_erase;
    } fcl_sys_t;

    typedef struct packed {
        logic       lock;
        logic [2:0] unused;
        logic [3:0] osc_temp_cal_value;
    } fcl_cal_b_t;

    typedef struct packed {
        logic       rd_en;
        logic       wr_en;
        logic [3:0] addr;
        logic [7:0] wr_data;
    } fcl_bus_t;

endpackage

// [fcl_fuse_config_loader.sv]
`timescale 1ns/1ns
module fcl_fuse_config_loader
    import fcl_pkg::*;
(
    input  wire logic        sys_clk,              // System clock
    input  wire logic        resetn,               // System reset, any source
    input  wire logic        fuse_initn,           // Nonvolatile first power-up
    input  wire logic        por_cause,            // Current reset is power-on
    input  wire fcl_bus_t    cpu_bus,              // CPU fuse access
    output logic [7:0]       cpu_rd_data,          // CPU read data
    input  wire fcl_bus_t    prog_debug_port,      // Debug port fuse access
    input  wire logic        pd_chip_erase,        // Debug port chip erase
    output logic [7:0]       pd_rd_data,           // Debug port read data
    output logic             pd_sysbus_grant,      // Debug port bus access
    output logic             eeprom_erase,         // EEPROM erase pulse
    input  wire logic [6:0]  cal16_value,          // Factory 16 MHz cal
    input  wire logic [3:0]  cal16_temp,           // Factory 16 MHz temp cal
    input  wire logic [6:0]  cal20_value,          // Factory 20 MHz cal
    input  wire logic [3:0]  cal20_temp,           // Factory 20 MHz temp cal
    input  wire logic        cal_wr_en,            // Run-time cal write
    input  wire logic        cal_wr_sel,           // 0 cal A, 1 cal B
    input  wire logic [7:0]  cal_wr_data,          // Run-time cal data
    output logic [6:0]       osc_calibration_a,    // Oscillator cal A
    output fcl_cal_b_t       osc_calibration_b,    // Oscillator cal B
    output logic [1:0]       osc_frequency_select, // Oscillator frequency
    output fcl_wdt_t         watchdog_control,     // Watchdog fields
    output fcl_bod_t         brownout_control,     // Brown-out fields
    output fcl_crc_t         boot_crc_source,      // Boot CRC source
    output logic             reset_pin_function,   // 1 reset, 0 GPIO
    output logic             eeprom_keep_on_erase, // EEPROM keep flag
    output logic             load_done             // Start-up copy done
);

    // ************************************************************
    // Fuse bank
    // ************************************************************
    logic [7:0] fuse_ff [FCL_NUM_BYTES];
    logic [7:0] nxt_fuse [FCL_NUM_BYTES];
    logic       lock_open_ff;
    logic       pd_write_ok;

    function automatic logic fcl_mapped(input logic [3:0] addr);
        logic hit;
        hit = 1'b0;
        unique case (addr)
            FCL_OFS_WDT,
            FCL_OFS_BOD,
            FCL_OFS_OSC,
            FCL_OFS_SYSA,
            FCL_OFS_SYSB,
            FCL_OFS_APP,
            FCL_OFS_BOOT,
            FCL_OFS_LOCK: hit = 1'b1;
            default:      hit = 1'b0;
        endcase
        return hit;
    endfunction

    assign pd_write_ok = prog_debug_port.wr_en && lock_open_ff &&
                         fcl_mapped(prog_debug_port.addr);

    // Cpu_bus.wr_en is deliberately never looked at
    always_comb begin
        nxt_fuse = fuse_ff;
        if (pd_write_ok) begin
            nxt_fuse[prog_debug_port.addr[3:0]] = prog_debug_port.wr_data;
        end
        // Erase restores the factory image, which also reopens the lock
        if (pd_chip_erase) begin
            nxt_fuse = FCL_FACTORY;
        end
    end

    // Not on resetn: contents live across every system reset
    always_ff @(posedge sys_clk or negedge fuse_initn) begin
        if (!fuse_initn) begin
            fuse_ff <= FCL_FACTORY;
        end else begin
            fuse_ff <= nxt_fuse;
        end
    end

    // ************************************************************
    // Read ports
    // ************************************************************
    logic [7:0] cpu_rd_data_ff;
    logic [7:0] nxt_cpu_rd_data;
    logic [7:0] pd_rd_data_ff;
    logic [7:0] nxt_pd_rd_data;

    function automatic logic [7:0] fcl_fetch(input logic [3:0] addr,
                                             input logic [7:0] bank [FCL_NUM_BYTES]);
        logic [7:0] val;
        val = FCL_ZERO;
        if (fcl_mapped(addr)) begin
            val = bank[addr];
        end
        return val;
    endfunction

    always_comb begin
        nxt_cpu_rd_data = cpu_rd_data_ff;
        nxt_pd_rd_data  = pd_rd_data_ff;
        if (cpu_bus.rd_en) begin
            nxt_cpu_rd_data = fcl_fetch(cpu_bus.addr, fuse_ff);
        end
        // A locked device hides fuse data from the debug port
        if (prog_debug_port.rd_en) begin
            nxt_pd_rd_data = lock_open_ff ?
                             fcl_fetch(prog_debug_port.addr, fuse_ff) : FCL_ZERO;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cpu_rd_data_ff <= FCL_ZERO;
            pd_rd_data_ff  <= FCL_ZERO;
        end else begin
            cpu_rd_data_ff <= nxt_cpu_rd_data;
            pd_rd_data_ff  <= nxt_pd_rd_data;
        end
    end

    assign cpu_rd_data = cpu_rd_data_ff;
    assign pd_rd_data  = pd_rd_data_ff;

    // ************************************************************
    // Start-up loader
    // ************************************************************
    fcl_state_t state_ff;
    fcl_state_t nxt_state;
    logic       load_now;
    fcl_wdt_t   fuse_wdt;
    fcl_bod_t   fuse_bod;
    fcl_osc_t   fuse_osc;
    fcl_sys_t   fuse_sys;

    assign fuse_wdt = fcl_wdt_t'(fuse_ff[FCL_OFS_WDT]);
    assign fuse_bod = fcl_bod_t'(fuse_ff[FCL_OFS_BOD]);
    assign fuse_osc = fcl_osc_t'(fuse_ff[FCL_OFS_OSC]);
    assign fuse_sys = fcl_sys_t'(fuse_ff[FCL_OFS_SYSA]);
    assign load_now = (state_ff == FCL_ST_LOAD);

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            FCL_ST_LOAD: nxt_state = FCL_ST_RUN;
            FCL_ST_RUN:  nxt_state = FCL_ST_RUN;
        endcase
    end

    // Copy happens once, on the first edge after reset release
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= FCL_ST_LOAD;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign load_done = (state_ff == FCL_ST_RUN);

    // ************************************************************
    // Target registers, all reset sources
    // ************************************************************
    fcl_wdt_t wdt_ff;
    fcl_wdt_t nxt_wdt;
    fcl_crc_t crc_ff;
    fcl_crc_t nxt_crc;
    logic     pin_ff;
    logic     nxt_pin;
    logic     keep_ff;
    logic     nxt_keep;
    logic     nxt_lock_open;
    logic     erase_ff;
    logic     nxt_erase;

    always_comb begin
        nxt_wdt       = wdt_ff;
        nxt_crc       = crc_ff;
        nxt_pin       = pin_ff;
        nxt_keep      = keep_ff;
        nxt_lock_open = lock_open_ff;
        if (load_now) begin
            nxt_wdt.window  = fuse_wdt.window;
            nxt_wdt.timeout = fuse_wdt.timeout;
            nxt_crc         = fuse_sys.boot_crc_source;
            nxt_pin         = fuse_sys.reset_pin_function;
            nxt_keep        = fuse_sys.eeprom_keep_on_erase;
            nxt_lock_open   = (fuse_ff[FCL_OFS_LOCK] == FCL_LOCK_OPEN);
        end
        // Lock state is the one seen at start-up, not the live fuse
        nxt_erase = pd_chip_erase && (!lock_open_ff || !keep_ff);
    end

    // Locked and GPIO reset pin are the safe values before the copy
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wdt_ff       <= fcl_wdt_t'(FCL_ZERO);
            crc_ff       <= FCL_CRC_FLASH;
            pin_ff       <= 1'b0;
            keep_ff      <= 1'b0;
            lock_open_ff <= 1'b0;
            erase_ff     <= 1'b0;
        end else begin
            wdt_ff       <= nxt_wdt;
            crc_ff       <= nxt_crc;
            pin_ff       <= nxt_pin;
            keep_ff      <= nxt_keep;
            lock_open_ff <= nxt_lock_open;
            erase_ff     <= nxt_erase;
        end
    end

    assign watchdog_control     = wdt_ff;
    assign boot_crc_source      = crc_ff;
    assign reset_pin_function   = pin_ff;
    assign eeprom_keep_on_erase = keep_ff;
    assign pd_sysbus_grant      = lock_open_ff;
    assign eeprom_erase         = erase_ff;

    // ************************************************************
    // Brown-out target, power-on reload only
    // ************************************************************
    fcl_bod_t bod_ff;
    fcl_bod_t nxt_bod;

    // Por_cause is sampled at the copy edge, never under the reset
    always_comb begin
        nxt_bod = bod_ff;
        if (load_now && por_cause) begin
            nxt_bod.brownout_level       = fuse_bod.brownout_level;
            nxt_bod.brownout_sample_rate = fuse_bod.brownout_sample_rate;
            nxt_bod.active_mode          = fuse_bod.active_mode;
            nxt_bod.sleep_mode           = fuse_bod.sleep_mode;
        end
    end

    // Only first power-up clears it, so warm resets keep the setting
    always_ff @(posedge sys_clk or negedge fuse_initn) begin
        if (!fuse_initn) begin
            bod_ff <= fcl_bod_t'(FCL_ZERO);
        end else begin
            bod_ff <= nxt_bod;
        end
    end

    assign brownout_control = bod_ff;

    // ************************************************************
    // Oscillator calibration
    // ************************************************************
    logic [6:0] cal_a_ff;
    logic [6:0] nxt_cal_a;
    fcl_cal_b_t cal_b_ff;
    fcl_cal_b_t nxt_cal_b;
    logic [1:0] freq_ff;
    logic [1:0] nxt_freq;
    logic       use_16m;

    assign use_16m = (fuse_osc.osc_frequency_select == FCL_FREQ_16M);

    // Reserved frequency codes fall back to the 20 MHz trim
    always_comb begin
        nxt_cal_a = cal_a_ff;
        nxt_cal_b = cal_b_ff;
        nxt_freq  = freq_ff;
        if (load_now) begin
            nxt_freq  = fuse_osc.osc_frequency_select;
            nxt_cal_a = use_16m ? cal16_value : cal20_value;
            nxt_cal_b.osc_temp_cal_value = use_16m ? cal16_temp : cal20_temp;
            nxt_cal_b.lock = fuse_osc.calibration_lock;
        end else if (cal_wr_en && !cal_b_ff.lock) begin
            if (cal_wr_sel) begin
                nxt_cal_b.osc_temp_cal_value = cal_wr_data[3:0];
            end else begin
                nxt_cal_a = cal_wr_data[6:0];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cal_a_ff <= 7'h00;
            cal_b_ff <= fcl_cal_b_t'(FCL_ZERO);
            freq_ff  <= FCL_FREQ_20M;
        end else begin
            cal_a_ff <= nxt_cal_a;
            cal_b_ff <= nxt_cal_b;
            freq_ff  <= nxt_freq;
        end
    end

    assign osc_calibration_a    = cal_a_ff;
    assign osc_calibration_b    = cal_b_ff;
    assign osc_frequency_select = freq_ff;

endmodule

// [fcl_fuse_config_loader_asserts.sv]
`timescale 1ns/1ns
module fcl_fuse_config_loader_asserts
    import fcl_pkg::*;
(
    input wire logic       sys_clk,              // Clock
    input wire logic       resetn,               // Reset
    input wire logic       por_cause,            // Power-on cause
    input wire fcl_bus_t   prog_debug_port,      // Debug request
    input wire logic       pd_chip_erase,        // Erase request
    input wire logic [7:0] pd_rd_data,           // Debug data
    input wire logic       pd_sysbus_grant,      // Debug open
    input wire logic       eeprom_erase,         // EEPROM erase
    input wire logic       cal_wr_en,            // Trim write
    input wire logic       cal_wr_sel,           // Trim select
    input wire logic [7:0] cal_wr_data,          // Trim data
    input wire logic [6:0] osc_calibration_a,    // Trim A
    input wire fcl_cal_b_t osc_calibration_b,    // Trim B
    input wire logic [1:0] osc_frequency_select, // Frequency
    input wire fcl_wdt_t   watchdog_control,     // Watchdog
    input wire fcl_bod_t   brownout_control,     // Brown-out
    input wire logic       eeprom_keep_on_erase, // Keep flag
    input wire logic       load_done             // Loaded
);
    // ********
    // Loader checks
    // ********
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    sequence s_loaded;
        $rose(load_done);
    endsequence
    sequence s_running;
        load_done && $past(load_done);
    endsequence

    property p_load;
        $rose(resetn) |=> s_loaded;
    endproperty
    a_load: assert property (p_load) else $error("load late");
    // Targets other than the trim registers move only at a load, so a fresh fuse write cannot leak
    property p_hold;
        s_running |-> $stable(watchdog_control) && $stable(brownout_control)
            && $stable(osc_frequency_select) && $stable(eeprom_keep_on_erase)
            && $stable(pd_sysbus_grant);
    endproperty
    a_hold: assert property (p_hold) else $error("target moved");
    property p_bod_kept;
        s_loaded ##0 !$past(por_cause) |-> $stable(brownout_control);
    endproperty
    a_bod_kept: assert property (p_bod_kept) else $error("bod reloaded");
    property p_cal_locked;
        load_done && cal_wr_en && osc_calibration_b.lock
            |=> $stable(osc_calibration_a) && $stable(osc_calibration_b);
    endproperty
    a_cal_locked: assert property (p_cal_locked) else $error("trim not locked");
    property p_cal_wr;
        load_done && cal_wr_en && !cal_wr_sel && !osc_calibration_b.lock
            |=> {1'b0, osc_calibration_a} == ($past(cal_wr_data) & 8'h7f);
    endproperty
    a_cal_wr: assert property (p_cal_wr) else $error("trim write lost");
    property p_pd_locked;
        prog_debug_port.rd_en && !pd_sysbus_grant |=> pd_rd_data == 8'h00;
    endproperty
    a_pd_locked: assert property (p_pd_locked) else $error("locked read leaks");
    property p_pd_hole;
        prog_debug_port.rd_en && prog_debug_port.addr inside {4'h3, 4'h4, 4'h9, [4'hb:4'hf]}
            |=> pd_rd_data == 8'h00;
    endproperty
    a_pd_hole: assert property (p_pd_hole) else $error("hole read nonzero");
    property p_erase;
        eeprom_erase == ($past(pd_chip_erase)
            && (!$past(pd_sysbus_grant) || !$past(eeprom_keep_on_erase)));
    endproperty
    a_erase: assert property (p_erase) else $error("eeprom erase wrong");
endmodule

bind fcl_fuse_config_loader fcl_fuse_config_loader_asserts u_chk (.*);

// [fcl_host_model.sv]
`timescale 1ns/1ns
module fcl_host_model
    import fcl_pkg::*;
(
    input  wire logic       sys_clk,         // Clock
    output fcl_bus_t        cpu_bus,         // CPU request
    output fcl_bus_t        prog_debug_port, // Debug request
    output logic            pd_chip_erase,   // Erase pulse
    input  wire logic [7:0] cpu_rd_data,     // CPU data
    input  wire logic [7:0] pd_rd_data,      // Debug data
    input  wire logic       eeprom_erase     // EEPROM erase
);
    // ********
    // Request driver
    // ********
    initial begin
        cpu_bus         = '0;
        prog_debug_port = '0;
        pd_chip_erase   = 1'b0;
    end

    // The bank stores reserved bits as written, so they must leave here as zero
    function automatic logic [7:0] clean(input logic [3:0] a, input logic [7:0] d);
        case (a)
            FCL_OFS_OSC:  return d & 8'h83;
            FCL_OFS_SYSA: return d & 8'hc9;
            FCL_OFS_SYSB: return d & 8'h07;
            default:      return d;
        endcase
    endfunction

    task automatic xfer(input logic pd, input logic wr, input logic [3:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        fcl_bus_t r;
        r = '{rd_en: !wr, wr_en: wr, addr: a, wr_data: clean(a, d)};
        @(posedge sys_clk);
        if (pd) prog_debug_port <= r;
        else cpu_bus <= r;
        @(posedge sys_clk);
        prog_debug_port <= '0;
        cpu_bus         <= '0;
        #1 q = pd ? pd_rd_data : cpu_rd_data;
    endtask

    task automatic erase(output logic hit);
        @(posedge sys_clk);
        pd_chip_erase <= 1'b1;
        @(posedge sys_clk);
        pd_chip_erase <= 1'b0;
        #1 hit = eeprom_erase;
    endtask
endmodule

// [testbench.sv]
`timescale 1ns/1ns
`define CHK(got, exp) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) begin \
            error_cnt++; \
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end

module testbench
    import fcl_pkg::*;
;
    logic       sys_clk, resetn, fuse_initn, por_cause, pd_chip_erase, hit;
    logic       pd_sysbus_grant, eeprom_erase, cal_wr_en, cal_wr_sel;
    logic       reset_pin_function, eeprom_keep_on_erase, load_done;
    logic [7:0] cpu_rd_data, pd_rd_data, cal_wr_data, q;
    logic [6:0] osc_calibration_a;
    logic [6:0] cal16_value = 7'h15;
    logic [6:0] cal20_value = 7'h2a;
    logic [3:0] cal16_temp  = 4'h3;
    logic [3:0] cal20_temp  = 4'hc;
    logic [1:0] osc_frequency_select;
    fcl_bus_t   cpu_bus, prog_debug_port;
    fcl_cal_b_t osc_calibration_b;
    fcl_wdt_t   watchdog_control;
    fcl_bod_t   brownout_control;
    fcl_crc_t   boot_crc_source;
    int         error_cnt, samples_checked, cycles;

    fcl_fuse_config_loader DUT (.*);
    fcl_host_model host (.*);

    // ********
    // Helpers
    // ********
    task automatic rd(input logic pd, input logic [3:0] a, input logic [7:0] e);
        host.xfer(pd, 1'b0, a, 8'h00, q);
        `CHK(q, e)
    endtask
    task automatic wr(input logic pd, input logic [3:0] a, input logic [7:0] d);
        host.xfer(pd, 1'b1, a, d, q);
    endtask
    task automatic cal(input logic s, input logic [7:0] d);
        @(posedge sys_clk);
        cal_wr_en   <= 1'b1;
        cal_wr_sel  <= s;
        cal_wr_data <= d;
        @(posedge sys_clk);
        cal_wr_en <= 1'b0;
        #1;
    endtask
    // Two edges after release: the load edge, which loads the lock state, then one more
    task automatic rst(input logic por);
        @(posedge sys_clk);
        resetn    <= 1'b0;
        por_cause <= por;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask

    // ********
    // Scenarios
    // ********
    task automatic t_factory();
        logic [7:0] img [16];
        img = '{2: 8'h02, 5: 8'hc0, 6: 8'h07, 10: 8'hc5, default: 8'h00};
        for (int i = 0; i < 32; i++) begin
            rd(i[4], i[3:0], img[i[3:0]]);
        end
        `CHK(load_done, 1'b1)
        `CHK(osc_frequency_select, FCL_FREQ_20M)
        `CHK(osc_calibration_a, cal20_value)
        `CHK(osc_calibration_b, {4'h0, cal20_temp})
        `CHK(boot_crc_source, FCL_CRC_DISABLED)
        `CHK({reset_pin_function, eeprom_keep_on_erase, pd_sysbus_grant}, 3'b001)
        cal(1'b0, 8'h11);
        `CHK(osc_calibration_a, 7'h11)
        cal(1'b1, 8'h8a);
        `CHK(osc_calibration_b, 8'h0a)
        host.erase(hit);
        `CHK(hit, 1'b1)
        $display("factory test done");
    endtask

    task automatic t_program();
        wr(1'b1, FCL_OFS_WDT, 8'h5a);
        wr(1'b1, FCL_OFS_BOD, 8'hf6);
        wr(1'b1, FCL_OFS_OSC, 8'hfd);
        wr(1'b1, FCL_OFS_SYSA, 8'h49);
        wr(1'b0, FCL_OFS_WDT, 8'hff);
        rd(1'b0, FCL_OFS_WDT, 8'h5a);
        rd(1'b0, FCL_OFS_OSC, 8'h81);
        `CHK(watchdog_control, 8'h00)
        rst(1'b0);
        `CHK(watchdog_control.window, 4'h5)
        `CHK(watchdog_control.timeout, 4'ha)
        `CHK(brownout_control, 8'h00)
        `CHK(osc_frequency_select, FCL_FREQ_16M)
        `CHK(osc_calibration_a, cal16_value)
        `CHK(osc_calibration_b, {4'h8, cal16_temp})
        `CHK(boot_crc_source, FCL_CRC_BOOT)
        `CHK({reset_pin_function, eeprom_keep_on_erase}, 2'b11)
        cal(1'b0, 8'h11);
        `CHK(osc_calibration_a, cal16_value)
        cal(1'b1, 8'h05);
        `CHK(osc_calibration_b, {4'h8, cal16_temp})
        rst(1'b1);
        `CHK(brownout_control, 8'hf6)
        $display("program test done");
    endtask

    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            wr(1'b1, FCL_OFS_BOD, {3'h2, 1'b0, m[1:0], ~m[1:0]});
            wr(1'b1, FCL_OFS_OSC, {6'h00, m[1:0]});
            rst(1'b1);
            `CHK(osc_frequency_select, m[1:0])
            `CHK(osc_calibration_a, (m == 1) ? cal16_value : cal20_value)
            `CHK(brownout_control.brownout_level, 3'h2)
            `CHK(brownout_control.brownout_sample_rate, 1'b0)
            `CHK(brownout_control.active_mode, m[1:0])
            `CHK(brownout_control.sleep_mode, ~m[1:0])
        end
        $display("mode test done");
    endtask

    task automatic t_erase();
        host.erase(hit);
        `CHK(hit, 1'b0)
        rd(1'b1, FCL_OFS_SYSA, 8'hc0);
        wr(1'b1, FCL_OFS_SYSA, 8'h49);
        wr(1'b1, FCL_OFS_LOCK, 8'h00);
        rst(1'b0);
        `CHK({pd_sysbus_grant, eeprom_keep_on_erase}, 2'b01)
        rd(1'b1, FCL_OFS_SYSA, 8'h00);
        wr(1'b1, FCL_OFS_WDT, 8'h33);
        rd(1'b0, FCL_OFS_WDT, 8'h00);
        host.erase(hit);
        `CHK(hit, 1'b1)
        rst(1'b0);
        `CHK(pd_sysbus_grant, 1'b1)
        $display("erase test done");
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // A hang counts as a mismatch; the full run needs well under this
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            results();
        end
    end

    initial begin
        resetn      = 1'b0;
        fuse_initn  = 1'b0;
        por_cause   = 1'b1;
        cal_wr_en   = 1'b0;
        cal_wr_sel  = 1'b0;
        cal_wr_data = 8'h00;
        repeat (2) @(posedge sys_clk);
        resetn     <= 1'b1;
        fuse_initn <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        t_factory();
        t_program();
        t_modes();
        t_erase();
        results();
    end
endmodule
